/* clk_sel.v */
// Master and programmable clock selection, status flags and interrupt logic
//
// Summary of operation
// - Master clock config: source select bits 1:0, prescaler bits 4:2, rest unused.
// - Source codes: 00 slow, 01 main, 11 pll, 10 reserved.
// - Master prescaler divides by two to the code, 1 to 64; 111 reserved.
// - Each programmable clock picks its source in bits 1:0, same coding.
// - Each programmable clock divides by its prescaler in bits 4:2.
// - Flag bits: osc 0, lock 2, master ready 3, programmable ready 8 to 10.
// - Writing ones to the enable register enables those sources; zeros ignored.
// - Writing ones to the disable register disables those sources; zeros ignored.
// - Status shows oscillator stable as one once the oscillator settled.
// - Status shows pll lock as one while the pll is locked.
// - Status shows master clock ready as one when the master clock is ready.
// - Status shows one ready flag per programmable clock.
// - Mask register reads zero for enabled, one for disabled sources.
// - Oscillator stable sets after programmed count times eight slow cycles.
// - Pll lock sets after programmed slow cycles following a pll write.
`timescale 1ns/100ps
`include "clk_sel_regs.vh"

module clk_sel #(
    parameter NUM_PCK = 3
) (
    // Clock, reset, clock enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Source clock ticks, one cycle each
    input wire slow_tick_i,
    input wire main_tick_i,
    input wire pll_tick_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Divided clock ticks and interrupt
    output reg mck_tick_o,
    output reg [NUM_PCK-1:0] pck_tick_o,
    output reg irq_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Terminal count of a prescaler: two to the code, minus one, at most 63
    function [5:0] prescale_code_limit;
        input [2:0] code;
        begin
            case (code)
                3'h0: prescale_code_limit = 6'h00;
                3'h1: prescale_code_limit = 6'h01;
                3'h2: prescale_code_limit = 6'h03;
                3'h3: prescale_code_limit = 6'h07;
                3'h4: prescale_code_limit = 6'h0f;
                3'h5: prescale_code_limit = 6'h1f;
                3'h6: prescale_code_limit = 6'h3f;
                default: prescale_code_limit = 6'h3f; // Reserved code behaves as divide by 64
            endcase
        end
    endfunction

    // Source tick of a select code; the reserved code gives no ticks
    function src_tick;
        input [1:0] sel;
        input slow;
        input main;
        input pll;
        begin
            case (sel)
                `SRC_SLOW: src_tick = slow;
                `SRC_MAIN: src_tick = main;
                `SRC_PLL: src_tick = pll;
                default: src_tick = 1'b0;
            endcase
        end
    endfunction

    // Register offset of a clock channel; channel 0 is the master clock
    function [7:0] chan_ofs;
        input integer idx;
        begin
            case (idx)
                0: chan_ofs = `OFS_MCK_CFG;
                1: chan_ofs = `OFS_PCK0_CFG;
                2: chan_ofs = `OFS_PCK1_CFG;
                default: chan_ofs = `OFS_PCK2_CFG;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam NCH = NUM_PCK + 1;
    localparam NFLAG = 11;

    reg [4:0] cfg_ff [0:NCH-1];
    reg [NCH-1:0] ready_ff;
    reg [NFLAG-1:0] irq_en_ff;
    reg [NFLAG-1:0] event_ff;
    reg [NFLAG-1:0] flags_d_ff;
    reg osc_en_ff;
    reg osc_byp_ff;
    reg [7:0] osc_cnt_cfg_ff;
    reg [10:0] osc_timer_ff;
    reg osc_stable_flag_ff;
    reg [5:0] pll_cnt_cfg_ff;
    reg [5:0] pll_timer_ff;
    reg pll_lock_ff;
    reg [NCH-1:0] tick_ff;

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Byte enables gate the enable, disable and event writes
    wire [31:0] wdat = wb_dat_i & wmask;
    wire [NFLAG-1:0] flags;
    wire [NCH-1:0] div_tick;
    wire [NCH-1:0] src_ok;
    wire [NCH-1:0] cfg_wr;
    wire main_ok = osc_stable_flag_ff;

    // ------------------------------------------------------------
    // Status flag vector
    // ------------------------------------------------------------
    assign flags[`BIT_OSC] = osc_stable_flag_ff;
    assign flags[1] = 1'b0;
    assign flags[`BIT_LOCK] = pll_lock_ff;
    assign flags[`BIT_MCK] = ready_ff[0];
    assign flags[7:4] = 4'h0;
    assign flags[`BIT_PCK0 +: NUM_PCK] = ready_ff[NCH-1:1];

    // ------------------------------------------------------------
    // Clock channels: index 0 is the master clock
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : chan
            // Counts source ticks up to the terminal count of the prescaler
            reg [5:0] div_cnt_ff;
            wire [4:0] cfg = cfg_ff[g];
            wire stick = src_tick(cfg[`SRC_MSB:`SRC_LSB], slow_tick_i, main_tick_i,
                pll_tick_i);
            wire at_lim = (div_cnt_ff == prescale_code_limit(cfg[`PRESCALE_CODE_MSB:`PRESCALE_CODE_LSB]));
            assign div_tick[g] = stick & at_lim;
            assign cfg_wr[g] = wr & wb_sel_i[0] & (wb_adr_i == chan_ofs(g));
            // Main and pll sources only count as usable once settled
            assign src_ok[g] = (cfg[`SRC_MSB:`SRC_LSB] == `SRC_SLOW) |
                ((cfg[`SRC_MSB:`SRC_LSB] == `SRC_MAIN) & main_ok) |
                ((cfg[`SRC_MSB:`SRC_LSB] == `SRC_PLL) & pll_lock_ff);

            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    div_cnt_ff <= 6'h00;
                end
                else if (ce_i)
                begin
                    if (cfg_wr[g])
                        div_cnt_ff <= 6'h00; // New divide restarts from zero
                    else if (stick)
                        div_cnt_ff <= at_lim ? 6'h00 : div_cnt_ff + 6'h01;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Configuration registers and ready flags
    // ------------------------------------------------------------
    integer i;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (i = 0; i < NCH; i = i + 1)
            begin
                cfg_ff[i] <= `CFG_RESET;
            end
            ready_ff <= {NCH{1'b0}};
            tick_ff <= {NCH{1'b0}};
        end
        else if (ce_i)
        begin
            // A second stage keeps every tick output straight from a flip-flop
            tick_ff <= div_tick;
            for (i = 0; i < NCH; i = i + 1)
            begin
                if (cfg_wr[i])
                begin
                    // The low byte lane carries both fields
                    cfg_ff[i] <= wb_dat_i[`PRESCALE_CODE_MSB:`SRC_LSB];
                    ready_ff[i] <= 1'b0; // Switching drops ready until the new clock runs
                end
                else if (div_tick[i] & src_ok[i])
                    ready_ff[i] <= 1'b1;
                else if (~src_ok[i])
                    ready_ff[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Main oscillator start-up
    // ------------------------------------------------------------
    wire osc_wr = wr & wb_sel_i[0] & (wb_adr_i == `OFS_OSC_CTRL);
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_en_ff <= 1'b0;
            osc_byp_ff <= 1'b0;
            osc_cnt_cfg_ff <= 8'h00;
            osc_timer_ff <= 11'h000;
            osc_stable_flag_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (osc_wr)
            begin
                osc_en_ff <= wb_dat_i[`OSC_EN_BIT];
                osc_byp_ff <= wb_dat_i[`OSC_BYP_BIT];
                if (wb_sel_i[1])
                    osc_cnt_cfg_ff <= wb_dat_i[`OSC_CNT_MSB:`OSC_CNT_LSB];
                // Rewriting the enable restarts the count rather than resuming it
                // Start-up time is the count times eight slow cycles
                osc_timer_ff <= {3'h0, (wb_sel_i[1] ? wb_dat_i[`OSC_CNT_MSB:`OSC_CNT_LSB] :
                    osc_cnt_cfg_ff)} << `OSC_MULT_SHIFT;
                if (wb_dat_i[`OSC_BYP_BIT])
                    osc_stable_flag_ff <= 1'b1; // Bypass needs no start-up
                else if (~wb_dat_i[`OSC_EN_BIT] | ~osc_en_ff)
                    osc_stable_flag_ff <= 1'b0;
            end
            else if (osc_en_ff & ~osc_stable_flag_ff)
            begin
                if (osc_timer_ff == 11'h000)
                    osc_stable_flag_ff <= 1'b1;
                else if (slow_tick_i)
                    osc_timer_ff <= osc_timer_ff - 11'h001;
            end
            else if (~osc_en_ff & ~osc_byp_ff)
                osc_stable_flag_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pll lock timer
    // ------------------------------------------------------------
    // Either low byte lane counts as a pll write
    wire pll_wr = wr & (wb_sel_i[0] | wb_sel_i[1]) & (wb_adr_i == `OFS_PLL_CTRL);
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pll_cnt_cfg_ff <= 6'h00;
            pll_timer_ff <= 6'h00;
            pll_lock_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (pll_wr)
            begin
                if (wb_sel_i[1])
                    pll_cnt_cfg_ff <= wb_dat_i[`PLL_CNT_MSB:`PLL_CNT_LSB];
                pll_timer_ff <= wb_sel_i[1] ? wb_dat_i[`PLL_CNT_MSB:`PLL_CNT_LSB] :
                    pll_cnt_cfg_ff;
                pll_lock_ff <= 1'b0; // Any write to the pll restarts locking
            end
            else if (~pll_lock_ff)
            begin
                if (pll_timer_ff == 6'h00)
                    pll_lock_ff <= 1'b1;
                else if (slow_tick_i)
                    pll_timer_ff <= pll_timer_ff - 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt enables, sticky events and output
    // ------------------------------------------------------------
    wire en_wr = wr & (wb_adr_i == `OFS_IRQ_EN);
    wire dis_wr = wr & (wb_adr_i == `OFS_IRQ_DIS);
    wire ev_wr = wr & (wb_adr_i == `OFS_EVENT);
    // One event per rising flag, so a flag that stays up cannot retrigger
    wire [NFLAG-1:0] flag_rise = flags & ~flags_d_ff;
    wire [NFLAG-1:0] nxt_irq_en = (irq_en_ff | (en_wr ? wdat[NFLAG-1:0] : {NFLAG{1'b0}})) &
        ~(dis_wr ? wdat[NFLAG-1:0] : {NFLAG{1'b0}});
    // A rising flag in the clearing cycle survives the clear
    wire [NFLAG-1:0] nxt_event = (event_ff & ~(ev_wr ? wdat[NFLAG-1:0] : {NFLAG{1'b0}})) |
        flag_rise;
    // Events keep the line up after a flag drops again
    wire nxt_irq = |(irq_en_ff & (flags | event_ff));

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_en_ff <= `FLAG_RESET;
            event_ff <= `FLAG_RESET;
            flags_d_ff <= `FLAG_RESET;
            irq_o <= 1'b0;
            mck_tick_o <= 1'b0;
            pck_tick_o <= {NUM_PCK{1'b0}};
        end
        else if (ce_i)
        begin
            irq_en_ff <= nxt_irq_en;
            event_ff <= nxt_event;
            flags_d_ff <= flags;
            irq_o <= nxt_irq;
            mck_tick_o <= tick_ff[0];
            pck_tick_o <= tick_ff[NCH-1:1];
        end
    end

    // ------------------------------------------------------------
    // Wishbone read and acknowledge
    // ------------------------------------------------------------
    reg [31:0] rdat;
    always @*
    begin
        // Write-only and unmapped offsets read as zero
        rdat = 32'h0000_0000;
        case (wb_adr_i)
            `OFS_MCK_CFG: rdat = {27'h0, cfg_ff[0]};
            `OFS_PCK0_CFG: rdat = {27'h0, cfg_ff[1]};
            `OFS_PCK1_CFG: rdat = {27'h0, cfg_ff[2]};
            `OFS_PCK2_CFG: rdat = {27'h0, cfg_ff[3]};
            `OFS_STATUS: rdat = {21'h0, flags};
            `OFS_IRQ_MASK: rdat = {21'h0, ~irq_en_ff & flag_impl(1'b0)};
            `OFS_OSC_CTRL: rdat = {16'h0, osc_cnt_cfg_ff, 6'h0, osc_byp_ff, osc_en_ff};
            `OFS_PLL_CTRL: rdat = {18'h0, pll_cnt_cfg_ff, 8'h00};
            `OFS_EVENT: rdat = {21'h0, event_ff};
            default: rdat = 32'h0000_0000;
        endcase
    end

    // Implemented flag positions; the rest of the mask reads zero
    function [NFLAG-1:0] flag_impl;
        input dummy;
        begin
            flag_impl = 11'h70d;
        end
    endfunction

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            // Ack blocks its own request in the ack cycle only; a strobe held past it is taken again in the cycle after
            // One wait state: ack on the edge after the request appears
            wb_ack_o <= req;
            if (req & ~wb_we_i)
                wb_dat_o <= rdat;
        end
    end

endmodule // clk_sel

/* clk_sel_regs.vh */
// Register offsets, field positions and reset values of the clock selection block
`ifndef CLK_SEL_REGS_VH
`define CLK_SEL_REGS_VH
// Byte offsets
`define OFS_MCK_CFG 8'h00
`define OFS_PCK0_CFG 8'h04
`define OFS_PCK1_CFG 8'h08
`define OFS_PCK2_CFG 8'h0c
`define OFS_IRQ_EN 8'h10
`define OFS_IRQ_DIS 8'h14
`define OFS_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1c
`define OFS_OSC_CTRL 8'h20
`define OFS_PLL_CTRL 8'h24
`define OFS_EVENT 8'h28
// Clock configuration fields
`define SRC_LSB 0
`define SRC_MSB 1
`define PRESCALE_CODE_LSB 2
`define PRESCALE_CODE_MSB 4
`define SRC_SLOW 2'h0
`define SRC_MAIN 2'h1
`define SRC_RSVD 2'h2
`define SRC_PLL 2'h3
`define PRESCALE_CODE_RSVD 3'h7
`define CFG_RESET 5'h00
// Status, enable, disable and mask bit positions
`define BIT_OSC 0
`define BIT_LOCK 2
`define BIT_MCK 3
`define BIT_PCK0 8
`define FLAG_RESET 11'h000
// Oscillator control fields
`define OSC_EN_BIT 0
`define OSC_BYP_BIT 1
`define OSC_CNT_LSB 8
`define OSC_CNT_MSB 15
`define OSC_MULT_SHIFT 3
// Pll control fields
`define PLL_CNT_LSB 8
`define PLL_CNT_MSB 13
`endif

/* clk_sel_sva.sv */
// Checker for bus timing, register layout and outputs of the clock selection block
`timescale 1ns/100ps
module clk_sel_sva #(
    parameter NUM_PCK = 3
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Source ticks
    input wire slow_tick_i,
    input wire main_tick_i,
    input wire pll_tick_i,
    // Wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Outputs
    input wire mck_tick_o,
    input wire [NUM_PCK-1:0] pck_tick_o,
    input wire irq_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
wire req = wb_cyc_i && wb_stb_i;
wire rd = req && !wb_we_i && wb_ack_o;
wire src = slow_tick_i || main_tick_i || pll_tick_i;
a_ack_answer: assert property (ce_i && req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
a_ack_single: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
a_ack_cause: assert property (ce_i && !req |=> !wb_ack_o)
    else $error("ack without request");
a_reset_quiet: assert property (disable iff (1'b0) rst_i && ce_i |=>
    !wb_ack_o && !irq_o && !mck_tick_o && pck_tick_o == 0) else $error("outputs up in reset");
a_mck_cause: assert property (mck_tick_o |-> $past(src, 2))
    else $error("master tick without source tick");
a_pck_cause: assert property (|pck_tick_o |-> $past(src, 2))
    else $error("prog tick without source tick");
a_cfg_unused: assert property (rd && wb_adr_i < 8'h10 |-> wb_dat_o[31:5] == 27'h0)
    else $error("config unused bits set");
a_flag_layout: assert property (rd && (wb_adr_i == 8'h18 || wb_adr_i == 8'h1c)
    |-> (wb_dat_o & 32'hfffff8f2) == 32'h0) else $error("flag outside layout");
a_wo_zero: assert property (rd && (wb_adr_i == 8'h10 || wb_adr_i == 8'h14)
    |-> wb_dat_o == 32'h0) else $error("write-only read not zero");
a_irq_off: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h14
    && wb_sel_i[1:0] == 2'h3 && wb_dat_i[10:0] == 11'h7ff |-> ##2 !irq_o)
    else $error("irq up after disabling all");
endmodule // clk_sel_sva
bind clk_sel clk_sel_sva #(.NUM_PCK(NUM_PCK)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .slow_tick_i(slow_tick_i), .main_tick_i(main_tick_i),
    .pll_tick_i(pll_tick_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mck_tick_o(mck_tick_o), .pck_tick_o(pck_tick_o), .irq_o(irq_o));

/* test_clk_sel.sv */
// Self-checking bench for the clock selection block
`timescale 1ns/100ps
`include "clk_sel_regs.vh"
module test_clk_sel;
reg clk_i = 1'b0;
reg rst_i = 1'b1;
reg ce_i = 1'b1;
reg slow_tick_i = 1'b0;
reg main_tick_i = 1'b0;
reg pll_tick_i = 1'b0;
reg wb_cyc_i = 1'b0;
reg wb_stb_i = 1'b0;
reg wb_we_i = 1'b0;
reg [7:0] wb_adr_i = 8'h00;
reg [3:0] wb_sel_i = 4'h0;
reg [31:0] wb_dat_i = 32'h0;
wire [31:0] wb_dat_o;
wire wb_ack_o;
wire mck_tick_o;
wire [2:0] pck_tick_o;
wire irq_o;
reg [7:0] cyc_cnt = 8'h00;
reg [31:0] rd;
integer err_count = 0;
integer compares = 0;
integer tk [0:3];
integer c;
clk_sel #(.NUM_PCK(3)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .slow_tick_i(slow_tick_i), .main_tick_i(main_tick_i), .pll_tick_i(pll_tick_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mck_tick_o(mck_tick_o), .pck_tick_o(pck_tick_o), .irq_o(irq_o));
initial forever #50 clk_i = ~clk_i;
// Slow ticks every 4 cycles so that one count window covers every divider
always @(posedge clk_i)
begin
    cyc_cnt <= cyc_cnt + 8'h01;
    slow_tick_i <= (cyc_cnt[1:0] == 2'h0);
    main_tick_i <= cyc_cnt[0];
    pll_tick_i <= 1'b1;
end
// ----------------------------------------
// Shared tasks
// ----------------------------------------
task wrap_up;
    begin
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
endtask
task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    end
endtask
task wb(input we, input [7:0] adr, input [31:0] dat);
    integer n;
    begin
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
        begin
            n = n + 1;
            if (n > 20)
            begin
                err_count = err_count + 1;
                wrap_up;
            end
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    end
endtask
task rdchk(input [7:0] adr, input [31:0] msk, input [31:0] exp, input string what);
    begin
        wb(1'b0, adr, 32'h0);
        check(what, rd & msk, exp);
    end
endtask
// Phase of a divider after a write is open, so mck, pck0 and pck1 counts allow one tick either way; pck2 must match exactly
task count(input integer exp0, input integer exp1, input integer exp2, input integer exp3);
    integer i;
    begin
        repeat (16) @(posedge clk_i);
        for (i = 0; i < 4; i = i + 1)
            tk[i] = 0;
        repeat (256)
        begin
            @(posedge clk_i);
            tk[0] = tk[0] + mck_tick_o;
            for (i = 0; i < 3; i = i + 1)
                tk[i + 1] = tk[i + 1] + pck_tick_o[i];
        end
        check("mck_ticks", tk[0] >= exp0 - 1 && tk[0] <= exp0 + 1, 1);
        check("pck0_ticks", tk[1] >= exp1 - 1 && tk[1] <= exp1 + 1, 1);
        check("pck1_ticks", tk[2] >= exp2 - 1 && tk[2] <= exp2 + 1, 1);
        check("pck2_ticks", tk[3] == exp3, 1);
    end
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task t_regs;
    begin
        rdchk(`OFS_MCK_CFG, 32'hffffffff, 32'h0, "mck_cfg_rst");
        rdchk(`OFS_IRQ_MASK, 32'hffffffff, 32'h70d, "mask_rst");
        rdchk(`OFS_STATUS, 32'h1, 32'h0, "osc_rst");
        rdchk(8'h3c, 32'hffffffff, 32'h0, "unmapped");
        rdchk(`OFS_IRQ_EN, 32'hffffffff, 32'h0, "en_wo");
        rdchk(`OFS_IRQ_DIS, 32'hffffffff, 32'h0, "dis_wo");
        wb(1'b1, `OFS_MCK_CFG, 32'hffffffed);
        rdchk(`OFS_MCK_CFG, 32'hffffffff, 32'h0d, "mck_cfg");
        wb(1'b1, `OFS_PCK2_CFG, 32'hffffffe3);
        rdchk(`OFS_PCK2_CFG, 32'hffffffff, 32'h03, "pck2_cfg");
    end
endtask
task t_div;
    begin
        wb(1'b1, `OFS_PCK2_CFG, 32'h18);
        for (c = 0; c < 7; c = c + 1)
        begin
            wb(1'b1, `OFS_MCK_CFG, c << 2);
            count(64 >> c, 64, 64, 1);
        end
        wb(1'b1, `OFS_MCK_CFG, 32'h0b);
        wb(1'b1, `OFS_PCK0_CFG, 32'h04);
        wb(1'b1, `OFS_PCK1_CFG, 32'h05);
        count(64, 32, 64, 1);
        rdchk(`OFS_STATUS, 32'h70d, 32'h50c, "ready");
    end
endtask
task t_osc_pll;
    begin
        wb(1'b1, `OFS_OSC_CTRL, 32'h201);
        rdchk(`OFS_STATUS, 32'h1, 32'h0, "osc_start");
        repeat (30) @(posedge clk_i);
        rdchk(`OFS_STATUS, 32'h1, 32'h0, "osc_wait");
        repeat (60) @(posedge clk_i);
        rdchk(`OFS_STATUS, 32'h201, 32'h201, "osc_done");
        wb(1'b1, `OFS_OSC_CTRL, 32'h0);
        rdchk(`OFS_STATUS, 32'h1, 32'h0, "osc_off");
        wb(1'b1, `OFS_PLL_CTRL, 32'h600);
        rdchk(`OFS_STATUS, 32'h4, 32'h0, "lock_start");
        repeat (10) @(posedge clk_i);
        rdchk(`OFS_STATUS, 32'h4, 32'h0, "lock_wait");
        repeat (40) @(posedge clk_i);
        rdchk(`OFS_STATUS, 32'h4, 32'h4, "lock_done");
    end
endtask
task t_irq;
    begin
        wb(1'b1, `OFS_EVENT, 32'h7ff);
        wb(1'b1, `OFS_IRQ_DIS, 32'h7ff);
        wb(1'b1, `OFS_IRQ_EN, 32'h1);
        repeat (3) @(posedge clk_i);
        check("irq_osc_low", irq_o, 1'b0);
        rdchk(`OFS_IRQ_MASK, 32'hffffffff, 32'h70c, "mask_en");
        wb(1'b1, `OFS_IRQ_EN, 32'h4);
        repeat (3) @(posedge clk_i);
        check("irq_lock", irq_o, 1'b1);
        wb(1'b1, `OFS_IRQ_DIS, 32'h0);
        rdchk(`OFS_IRQ_MASK, 32'hffffffff, 32'h708, "mask_keep");
        wb(1'b1, `OFS_IRQ_DIS, 32'h4);
        repeat (3) @(posedge clk_i);
        check("irq_lock_off", irq_o, 1'b0);
        wb(1'b1, `OFS_OSC_CTRL, 32'h2);
        repeat (3) @(posedge clk_i);
        check("irq_osc", irq_o, 1'b1);
        rdchk(`OFS_EVENT, 32'h1, 32'h1, "event_osc");
        wb(1'b1, `OFS_EVENT, 32'h1);
        rdchk(`OFS_EVENT, 32'h1, 32'h0, "event_clear");
        wb(1'b1, `OFS_IRQ_DIS, 32'h7ff);
        repeat (3) @(posedge clk_i);
        check("irq_all_off", irq_o, 1'b0);
    end
endtask
initial
begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_div;
    t_osc_pll;
    t_irq;
    wrap_up;
end
endmodule // test_clk_sel
